// File: hw/mftcp_pkg.sv
package mftcp_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int KP_LONG_MS = 55;
   localparam int KP_SHORT_MS = 30;
   localparam int KP_LONG_CYC = (CLK_HZ / 1000) * KP_LONG_MS;
   localparam int KP_SHORT_CYC = (CLK_HZ / 1000) * KP_SHORT_MS;
   localparam int CLKDIV = 4;
   localparam int WORD_W = 8;
   // ------------------------------------------------------------
   // byte layout and reset values
   // ------------------------------------------------------------
   localparam int BIT_CMD = 7;
   localparam int BIT_CHN = 6;
   localparam logic [7:0] ALIVE_BYTE = 8'h00;
   localparam logic [7:0] KP_BIN_CODE = 8'h0d;
   localparam logic [7:0] KP_2OF6_CODE = 8'h24;

   typedef struct packed {
      logic chan;
      logic [5:0] code;
   } mftcp_tone_t;

   typedef enum logic [1:0] {
      MFTCP_IDLE = 2'b00,
      MFTCP_SHIFT = 2'b01
   } mftcp_sh_t;
endpackage : mftcp_pkg

// File: hw/mftcp_port.sv
`timescale 1ns/100ps
module mftcp_port
   import mftcp_pkg::*;
#(
   parameter int KP_LONG = KP_LONG_CYC,
   parameter int KP_SHORT = KP_SHORT_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic host_data_bus_oe,
   output logic inbound_latch_empty,
   output logic outbound_latch_full,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   input wire logic cmd_taken,
   input wire logic tone_present,
   input wire logic [6:0] tone_in,
   input wire logic binary_mode,
   input wire logic kp_long,
   output logic kp_detect,
   input wire logic [WORD_W-1:0] tx_word,
   input wire logic tx_load,
   input wire logic sclk,
   output logic serial_tx_out,
   output logic system_clock_out
);
   initial begin
      if (KP_SHORT < 1 || KP_LONG < KP_SHORT) $error("bad kp counts");
      if (WORD_W < 2 || WORD_W > 15) $error("bad word width");
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic wr_m_r, wr_s_r, wr_d_r, rd_m_r, rd_s_r, rd_d_r, sc_m_r, sc_s_r, sc_d_r;
   logic [7:0] din_m_r, din_s_r;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         {wr_m_r, wr_s_r, wr_d_r, rd_m_r, rd_s_r, rd_d_r} <= 6'h3f;
         {sc_m_r, sc_s_r, sc_d_r} <= 3'h0;
         din_m_r <= 8'h00;
         din_s_r <= 8'h00;
      end else begin
         wr_m_r <= wr_n;
         wr_s_r <= wr_m_r;
         wr_d_r <= wr_s_r;
         rd_m_r <= rd_n;
         rd_s_r <= rd_m_r;
         rd_d_r <= rd_s_r;
         sc_m_r <= sclk;
         sc_s_r <= sc_m_r;
         sc_d_r <= sc_s_r;
         din_m_r <= host_data_bus_in;
         din_s_r <= din_m_r;
      end
   end
   logic wr_fall, wr_rise, rd_fall, sc_rise;
   assign wr_fall = wr_d_r & ~wr_s_r;
   assign wr_rise = ~wr_d_r & wr_s_r;
   assign rd_fall = rd_d_r & ~rd_s_r;
   assign sc_rise = ~sc_d_r & sc_s_r;

   // ------------------------------------------------------------
   // inbound latch
   // ------------------------------------------------------------
   // flag is high while occupied; a new write strobe wins over consumption
   always_ff @(posedge clock) begin
      if (!nrst) begin
         inbound_latch_empty <= 1'b0;
         cmd_byte <= 8'h00;
         cmd_valid <= 1'b0;
      end else begin
         if (wr_fall) begin
            inbound_latch_empty <= 1'b1;
         end else if (cmd_valid && cmd_taken) begin
            inbound_latch_empty <= 1'b0;
         end
         if (wr_rise) begin
            cmd_byte <= din_s_r;
            cmd_valid <= 1'b1;
         end else if (cmd_taken) begin
            cmd_valid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // outbound latch and bus drive
   // ------------------------------------------------------------
   logic [7:0] result_nxt;
   always_comb begin
      result_nxt = {1'b0, tone_in[6], tone_in[5:0]};
      if (binary_mode) begin
         result_nxt[5:4] = 2'b00;
      end
   end
   logic kp_evt, is_kp, tone_evt;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         host_data_bus_out <= ALIVE_BYTE;
         outbound_latch_full <= 1'b1;
         host_data_bus_oe <= 1'b0;
      end else begin
         if (tone_evt) begin
            host_data_bus_out <= result_nxt;
            outbound_latch_full <= 1'b0;
         end else if (rd_fall) begin
            outbound_latch_full <= 1'b1;
         end
         host_data_bus_oe <= ~rd_s_r;
      end
   end

   // ------------------------------------------------------------
   // tone qualification
   // ------------------------------------------------------------
   // kp code depends on coding format; other tones use the short time
   logic [6:0] tone_last_r;
   logic [31:0] on_cnt_r;
   logic done_r;
   int need;
   assign is_kp = tone_in[5:0] == (binary_mode ? KP_BIN_CODE[5:0] : KP_2OF6_CODE[5:0]);
   assign need = (is_kp && kp_long) ? KP_LONG : KP_SHORT;
   assign tone_evt = tone_present && !done_r && (on_cnt_r == 32'(need - 1));
   assign kp_evt = tone_evt && is_kp;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         on_cnt_r <= 32'h0;
         done_r <= 1'b0;
         tone_last_r <= 7'h00;
         kp_detect <= 1'b0;
      end else begin
         tone_last_r <= tone_in;
         kp_detect <= kp_evt;
         if (!tone_present || tone_in != tone_last_r) begin
            on_cnt_r <= 32'h0;
            done_r <= 1'b0;
         end else if (!done_r) begin
            on_cnt_r <= on_cnt_r + 32'h1;
            if (tone_evt) begin
               done_r <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // serial transmit
   // ------------------------------------------------------------
   // bit changes only at sclk rise, so it holds a whole bit period
   logic [WORD_W-1:0] sh_r;
   mftcp_sh_t sh_st_r;
   logic [3:0] sh_cnt_r;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sh_r <= '0;
         sh_st_r <= MFTCP_IDLE;
         sh_cnt_r <= 4'h0;
         serial_tx_out <= 1'b0;
      end else begin
         case (sh_st_r)
            MFTCP_IDLE: begin
               if (tx_load) begin
                  sh_r <= tx_word;
                  sh_cnt_r <= 4'(WORD_W);
                  sh_st_r <= MFTCP_SHIFT;
               end
            end
            MFTCP_SHIFT: begin
               if (sc_rise) begin
                  serial_tx_out <= sh_r[WORD_W-1];
                  sh_r <= {sh_r[WORD_W-2:0], 1'b0};
                  sh_cnt_r <= sh_cnt_r - 4'h1;
                  if (sh_cnt_r == 4'h1) begin
                     sh_st_r <= MFTCP_IDLE;
                  end
               end
            end
            default: sh_st_r <= MFTCP_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // clock divider
   // ------------------------------------------------------------
   logic [1:0] div_r;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_r <= 2'h0;
         system_clock_out <= 1'b0;
      end else begin
         div_r <= div_r + 2'h1;
         if (div_r[0]) begin
            system_clock_out <= ~system_clock_out;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_wr_sets_flag: assert property (@(posedge clock) disable iff (!nrst)
      wr_fall |=> inbound_latch_empty) else $error("flag not set");
   a_wr_captures: assert property (@(posedge clock) disable iff (!nrst)
      wr_rise |=> cmd_byte == $past(din_s_r) && cmd_valid) else $error("no capture");
   a_consume_clears: assert property (@(posedge clock) disable iff (!nrst)
      cmd_valid && cmd_taken && !wr_fall |=> !inbound_latch_empty) else $error("flag stuck");
   a_tone_full: assert property (@(posedge clock) disable iff (!nrst)
      tone_evt |=> !outbound_latch_full && !host_data_bus_out[BIT_CMD]) else $error("no full");
   a_rd_frees: assert property (@(posedge clock) disable iff (!nrst)
      rd_fall && !tone_evt |=> outbound_latch_full) else $error("full stuck");
   a_bus_drive: assert property (@(posedge clock) disable iff (!nrst)
      !rd_s_r |=> host_data_bus_oe) else $error("bus not driven");
   a_bus_release: assert property (@(posedge clock) disable iff (!nrst)
      rd_s_r |=> !host_data_bus_oe) else $error("bus not released");
   a_tx_steady: assert property (@(posedge clock) disable iff (!nrst)
      !sc_rise |=> $stable(serial_tx_out)) else $error("tx moved");
   a_clk_quarter: assert property (@(posedge clock) disable iff (!nrst)
      $changed(system_clock_out) |=> ##1 $changed(system_clock_out)) else $error("div bad");
   a_kp_long: assert property (@(posedge clock) disable iff (!nrst)
      kp_evt && kp_long |-> on_cnt_r == 32'(KP_LONG - 1)) else $error("kp long time");
   a_kp_short: assert property (@(posedge clock) disable iff (!nrst)
      kp_evt && !kp_long |-> on_cnt_r == 32'(KP_SHORT - 1)) else $error("kp short time");
   a_kp_pulse: assert property (@(posedge clock) disable iff (!nrst)
      kp_detect |=> !kp_detect) else $error("kp twice");
   a_flag_holds: assert property (@(posedge clock) disable iff (!nrst)
      inbound_latch_empty && !(cmd_valid && cmd_taken) |=> inbound_latch_empty) else $error("flag dropped");
   a_cmd_consumed: assert property (@(posedge clock) disable iff (!nrst)
      cmd_valid && cmd_taken && !wr_rise |=> !cmd_valid) else $error("command kept");
   a_cmd_overwrite: assert property (@(posedge clock) disable iff (!nrst)
      wr_rise && cmd_valid |=> cmd_byte == $past(din_s_r)) else $error("no overwrite");

   a_result_fmt: assert property (@(posedge clock) disable iff (!nrst)
      !outbound_latch_full |-> !host_data_bus_out[BIT_CMD]) else $error("result bit 7 set");
   a_result_chan: assert property (@(posedge clock) disable iff (!nrst)
      tone_evt |=> host_data_bus_out[BIT_CHN] == $past(tone_in[6])) else $error("channel bit wrong");
   a_rd_keeps_byte: assert property (@(posedge clock) disable iff (!nrst)
      host_data_bus_oe && !tone_evt |=> $stable(host_data_bus_out)) else $error("byte moved");
   a_tx_msb: assert property (@(posedge clock) disable iff (!nrst)
      sc_rise && sh_st_r == MFTCP_SHIFT |=> serial_tx_out == $past(sh_r[WORD_W-1])) else $error("not msb");
   a_tx_idle: assert property (@(posedge clock) disable iff (!nrst)
      sh_st_r == MFTCP_IDLE |=> $stable(serial_tx_out)) else $error("tx moved idle");

   // reset checks watch the reset itself, so no disable here
   a_reset_state: assert property (@(posedge clock)
      !nrst |=> outbound_latch_full && !host_data_bus_oe && !inbound_latch_empty) else $error("reset state");
   a_alive_byte: assert property (@(posedge clock)
      !nrst |=> host_data_bus_out == ALIVE_BYTE) else $error("alive byte");

   c_write: cover property (@(posedge clock) disable iff (!nrst) wr_fall ##[1:20] wr_rise);
   c_read: cover property (@(posedge clock) disable iff (!nrst) tone_evt ##[1:20] rd_fall);
   c_kp: cover property (@(posedge clock) disable iff (!nrst) kp_evt);
   c_kp_long: cover property (@(posedge clock) disable iff (!nrst) kp_evt && kp_long);
   c_serial: cover property (@(posedge clock) disable iff (!nrst) sh_st_r == MFTCP_SHIFT && sc_rise);

   // ------------------------------------------------------------
   // divider watch
   // ------------------------------------------------------------
   // counts cycles without a system_clock_out edge; two is the longest legal gap after reset
   logic ck_prev_r;
   logic [2:0] ck_gap_r;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ck_prev_r <= 1'b0;
         ck_gap_r <= 3'h0;
      end else begin
         ck_prev_r <= system_clock_out;
         if (ck_prev_r != system_clock_out) begin
            ck_gap_r <= 3'h0;
         end else if (ck_gap_r != 3'h7) begin
            ck_gap_r <= ck_gap_r + 3'h1;
         end
      end
   end
   a_clk_gap: assert property (@(posedge clock) disable iff (!nrst)
      ck_gap_r <= 3'h2) else $error("clock out stalled");
endmodule : mftcp_port

// File: tb/mftcp_host.sv
`timescale 1ns/100ps
module mftcp_host (
   input wire logic clock,
   input wire logic busy_flag,
   output logic wr_n,
   output logic rd_n,
   output logic [7:0] bus_in,
   input wire logic [7:0] bus_out,
   input wire logic bus_oe
);
   logic [7:0] drv_r = 8'h00;
   logic drv_en = 1'b0;
   initial begin
      wr_n = 1'b1;
      rd_n = 1'b1;
   end
   // released bus shows bus_out while bus_oe is high, else the inverse of the last value, not a stale copy
   assign bus_in = drv_en ? drv_r : (bus_oe ? bus_out : ~drv_r);

   task automatic write(input logic [7:0] b, input logic polite);
      int k;
      k = 0;
      while (polite && busy_flag !== 1'b0 && k < 50) begin
         @(posedge clock);
         k++;
      end
      @(posedge clock) #1;
      wr_n = 1'b0;
      drv_r = b;
      drv_en = 1'b1;
      repeat (6) @(posedge clock);
      #1 wr_n = 1'b1;
      repeat (3) @(posedge clock); // data held past the synchroniser
      #1 drv_en = 1'b0;
   endtask : write

   task automatic read(output logic [7:0] b);
      int k;
      @(posedge clock) #1;
      rd_n = 1'b0;
      for (k = 0; k < 8 && bus_oe !== 1'b1; k++) begin
         @(posedge clock) #1;
      end
      b = bus_out;
      rd_n = 1'b1;
   endtask : read
endmodule : mftcp_host

// File: tb/mftcp_port_tb.sv
`timescale 1ns/100ps
module mftcp_port_tb;
   import mftcp_pkg::*;
   localparam int KL = 40;
   localparam int KS = 20;
   logic clock = 1'b0, nrst = 1'b0, wr_n, rd_n, host_data_bus_oe, inbound_latch_empty, outbound_latch_full;
   logic [7:0] host_data_bus_in, host_data_bus_out, cmd_byte, rb;
   logic cmd_valid, cmd_taken = 1'b0, tone_present = 1'b0, binary_mode = 1'b0, kp_long = 1'b0, kp_detect;
   logic [6:0] tone_in = 7'h00;
   logic [7:0] tx_word = 8'h00;
   logic tx_load = 1'b0, sclk = 1'b0, serial_tx_out, system_clock_out;
   int n_mismatch = 0, n_tests = 0;

   always #20 clock = ~clock;

   mftcp_port #(.KP_LONG(KL), .KP_SHORT(KS)) u_mftcp_port (.clock(clock), .nrst(nrst), .wr_n(wr_n),
      .rd_n(rd_n), .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
      .host_data_bus_oe(host_data_bus_oe), .inbound_latch_empty(inbound_latch_empty),
      .outbound_latch_full(outbound_latch_full), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .cmd_taken(cmd_taken), .tone_present(tone_present), .tone_in(tone_in), .binary_mode(binary_mode),
      .kp_long(kp_long), .kp_detect(kp_detect), .tx_word(tx_word), .tx_load(tx_load), .sclk(sclk),
      .serial_tx_out(serial_tx_out), .system_clock_out(system_clock_out));
   mftcp_host u_mftcp_host (.clock(clock), .busy_flag(inbound_latch_empty), .wr_n(wr_n), .rd_n(rd_n),
      .bus_in(host_data_bus_in), .bus_out(host_data_bus_out), .bus_oe(host_data_bus_oe));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk

   task automatic stop_test();
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test

   task automatic wr_take(input logic [7:0] a, input logic [7:0] b);
      u_mftcp_host.write(a, 1'b1);
      if (b !== a) u_mftcp_host.write(b, 1'b0);
      repeat (3) @(posedge clock);
      #1 chk(cmd_valid === 1'b1 && cmd_byte === b, "command byte");
      cmd_taken = 1'b1;
      @(posedge clock) #1 cmd_taken = 1'b0;
      @(posedge clock) #1 chk(inbound_latch_empty === 1'b0, "latch not freed");
   endtask : wr_take

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_write();
      fork
         wr_take(8'h9a, 8'h9a);
         begin
            repeat (6) @(posedge clock);
            #2 chk(inbound_latch_empty === 1'b1, "occupied flag");
         end
      join
      wr_take(8'h81, 8'hc2);
   endtask : t_write

   task automatic t_tone(input logic bm, input logic ch, input logic [5:0] code, input logic lng);
      int n;
      @(posedge clock) #1;
      binary_mode = bm;
      kp_long = lng;
      tone_in = {ch, code};
      tone_present = 1'b1;
      for (n = 0; n < 120 && outbound_latch_full !== 1'b0; n++) begin
         @(posedge clock) #1;
         if (kp_detect === 1'b1) chk(n >= (lng ? KL : KS) - 1 && n <= (lng ? KL : KS) + 4, "kp time");
      end
      chk(n >= KS && outbound_latch_full === 1'b0, "tone flag");
      chk(host_data_bus_out === {1'b0, ch, code}, "result byte");
      tone_present = 1'b0;
      u_mftcp_host.read(rb);
      chk(rb === {1'b0, ch, code} && outbound_latch_full === 1'b1, "read");
      repeat (5) @(posedge clock);
      #1 chk(host_data_bus_oe === 1'b0, "bus not released");
   endtask : t_tone

   task automatic t_serial();
      int i;
      @(posedge clock) #1 tx_word = 8'ha5;
      tx_load = 1'b1;
      @(posedge clock) #1 tx_load = 1'b0;
      for (i = 7; i >= 0; i--) begin
         sclk = 1'b1;
         repeat (4) @(posedge clock);
         #1 sclk = 1'b0;
         repeat (4) @(posedge clock);
         #1 chk(serial_tx_out === tx_word[i], "serial bit");
      end
   endtask : t_serial

   task automatic t_system_clock_out();
      int i, r;
      logic p;
      r = 0;
      p = system_clock_out;
      for (i = 0; i < 40; i++) begin
         @(posedge clock) #1;
         if (p === 1'b0 && system_clock_out === 1'b1) r++;
         p = system_clock_out;
      end
      chk(r == 10, "clock out rate");
   endtask : t_system_clock_out

   initial begin
      repeat (3) @(posedge clock);
      #1 nrst = 1'b1;
      chk(host_data_bus_oe === 1'b0 && outbound_latch_full === 1'b1, "reset outputs");
      chk(inbound_latch_empty === 1'b0 && host_data_bus_out === ALIVE_BYTE, "alive byte");
      t_write();
      t_tone(1'b1, 1'b1, 6'h05, 1'b0);
      t_tone(1'b0, 1'b0, 6'h12, 1'b0);
      t_tone(1'b1, 1'b0, KP_BIN_CODE[5:0], 1'b1);
      t_tone(1'b0, 1'b1, KP_2OF6_CODE[5:0], 1'b0);
      t_serial();
      t_system_clock_out();
      stop_test();
   end

   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      stop_test();
   end
endmodule : mftcp_port_tb
